// ===== mtc_pkg.sv
package mtc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INSTR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SRC_A_LO = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SRC_A_HI = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SRC_B_LO = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SRC_B_HI = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_VIEW_SEL = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_VIEW_LO = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_VIEW_HI = 8'h24;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_FLOAT_MODE_BIT = 0;
  localparam int CTRL_RELEASE2_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RSVD_BIT = 1;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [63:0] DWORD_RESET = 64'h0000_0000_0000_0000;
  localparam int VIEW_IDX_LSB = 0;
  localparam int VIEW_SPACE_LSB = 8;

  // View spaces for reading back the target register files.
  localparam logic [1:0] SPACE_SYSCTL = 2'h0;
  localparam logic [1:0] SPACE_FLOAT = 2'h1;
  localparam logic [1:0] SPACE_COPROC2 = 2'h2;
  localparam logic [1:0] SPACE_PRODUCT = 2'h3;

  // ----------------------------------------------------------------
  // Instruction encoding
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_SPECIAL = 6'h00;
  localparam logic [5:0] OPC_SYSCTL = 6'h10;
  localparam logic [5:0] OPC_FLOAT = 6'h11;
  localparam logic [5:0] OPC_COPROC2 = 6'h12;
  localparam logic [5:0] OPC_SPECIAL2 = 6'h1c;
  localparam logic [4:0] SUB_MOVE_LOW = 5'h04;
  localparam logic [4:0] SUB_MOVE_HIGH = 5'h07;
  localparam logic [5:0] FN_MSUB_UNSIGNED = 6'h05;
  localparam logic [5:0] FN_WRITE_UPPER = 6'h11;
  localparam logic [5:0] FN_WRITE_BOTTOM = 6'h13;

  // Which system-control registers (sel 0) are 64 bits wide.
  localparam logic [31:0] SYSCTL_WIDE_MASK = 32'h0000_0300;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SYSCTL = 4'h1,
    OP_FLOAT_LO = 4'h2,
    OP_FLOAT_HI = 4'h3,
    OP_CP2_LO = 4'h4,
    OP_CP2_HI = 4'h5,
    OP_UPPER = 4'h6,
    OP_BOTTOM = 4'h7,
    OP_UNSIGNED_MULTIPLY_SUBTRACT = 4'h8
  } mtc_op_t;

endpackage : mtc_pkg

// ===== mtc_mul_if.sv
`timescale 1ns/10ps
interface mtc_mul_if;
  logic start;
  logic [31:0] op_b;
  logic [31:0] op_a;
  logic [63:0] acc;
  logic busy;
  logic done;
  logic [63:0] result;

  modport host (output start, output op_b, output op_a, output acc,
                input busy, input done, input result);
  modport unit (input start, input op_b, input op_a, input acc,
                output busy, output done, output result);
endinterface : mtc_mul_if

// ===== mtc_msub.sv
`timescale 1ns/10ps
module mtc_msub
  import mtc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  mtc_mul_if.unit mi
);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } mtc_mstate_t;

  mtc_mstate_t state;
  logic [63:0] mcand;
  logic [31:0] mplier;
  logic [63:0] prod;
  logic [63:0] acc;

  assign mi.busy = (state == ST_RUN);

  // Shift-add multiply that stops once the multiplier runs out of set
  // bits, so a short multiplier in op_a finishes early.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      mcand <= DWORD_RESET;
      mplier <= WORD_RESET;
      prod <= DWORD_RESET;
      acc <= DWORD_RESET;
    end else begin
      case (state)
        ST_IDLE: begin
          if (mi.start) begin
            mcand <= {32'h0000_0000, mi.op_b};
            mplier <= mi.op_a;
            prod <= DWORD_RESET;
            acc <= mi.acc;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (mplier == WORD_RESET) begin
            state <= ST_IDLE;
          end else begin
            if (mplier[0]) begin
              prod <= prod + mcand;
            end
            mcand <= {mcand[62:0], 1'b0};
            mplier <= {1'b0, mplier[31:1]};
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // The 64-bit product of zero-extended words leaves the pair.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mi.done <= 1'b0;
      mi.result <= DWORD_RESET;
    end else begin
      mi.done <= (state == ST_RUN) && (mplier == WORD_RESET);
      if ((state == ST_RUN) && (mplier == WORD_RESET)) begin
        mi.result <= acc - prod;
      end
    end
  end

endmodule : mtc_msub

// ===== mtc_unit.sv
`timescale 1ns/10ps
// Function
// - Unsigned multiply-subtract of low words from product pair.
// - Major 010000, sub 00100 moves source A to system control.
// - Wide system-control targets take 64 bits, others low 32.
// - Low float move fills low word; upper half is not defined.
// - Low coprocessor-2 move fills low word; upper half undefined.
// - Coprocessor-2 selector meaning belongs to that coprocessor.
// - High float move writes bits 63..32 and keeps the low word.
// - High coprocessor-2 move writes 63..32 and keeps low word.
// - Before release 2 both high moves raise reserved-instruction.
// - Upper and bottom product writes copy source B, no exception.
// - No spacing is needed between product read and product write.
module mtc_unit
  import mtc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic reserved_instr
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [63:0] sext32(input logic [31:0] w);
    sext32 = {{32{w[31]}}, w};
  endfunction : sext32

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    strb_merge = m;
  endfunction : strb_merge

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CTRL, OFS_STATUS, OFS_INSTR, OFS_SRC_A_LO, OFS_SRC_A_HI,
      OFS_SRC_B_LO, OFS_SRC_B_HI, OFS_VIEW_SEL, OFS_VIEW_LO,
      OFS_VIEW_HI: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  function automatic mtc_op_t decode_op(input logic [31:0] ins);
    decode_op = OP_NONE;
    case (ins[31:26])
      OPC_SYSCTL: begin
        if (ins[25:21] == SUB_MOVE_LOW) begin
          decode_op = OP_SYSCTL;
        end
      end
      OPC_FLOAT: begin
        if (ins[25:21] == SUB_MOVE_LOW) begin
          decode_op = OP_FLOAT_LO;
        end else if (ins[25:21] == SUB_MOVE_HIGH) begin
          decode_op = OP_FLOAT_HI;
        end
      end
      OPC_COPROC2: begin
        if (ins[25:21] == SUB_MOVE_LOW) begin
          decode_op = OP_CP2_LO;
        end else if (ins[25:21] == SUB_MOVE_HIGH) begin
          decode_op = OP_CP2_HI;
        end
      end
      OPC_SPECIAL: begin
        if (ins[5:0] == FN_WRITE_UPPER) begin
          decode_op = OP_UPPER;
        end else if (ins[5:0] == FN_WRITE_BOTTOM) begin
          decode_op = OP_BOTTOM;
        end
      end
      OPC_SPECIAL2: begin
        if (ins[5:0] == FN_MSUB_UNSIGNED) begin
          decode_op = OP_UNSIGNED_MULTIPLY_SUBTRACT;
        end
      end
      default: decode_op = OP_NONE;
    endcase
  endfunction : decode_op

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0] ctrl;
  logic [63:0] src_a;
  logic [63:0] src_b;
  logic [9:0] view_sel;
  logic [63:0] upper_product_register;
  logic [63:0] bottom_product_register;
  logic [63:0] sysctl_file [32];
  logic [63:0] float_register [32];
  logic [63:0] coproc_register [32];
  logic product_fresh;

  logic access;
  logic wr_ok;
  logic stall;
  logic exec;
  mtc_op_t op;
  logic [4:0] idx;
  logic [2:0] sel;
  logic high_refused;
  logic rsvd_set;
  logic rsvd_clr;
  logic [63:0] view_data;
  logic [31:0] next_prdata;

  mtc_mul_if mi ();

  mtc_msub u_msub (
    .pclk(pclk),
    .presetn(presetn),
    .mi(mi)
  );

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // A new instruction, or a read that could see the product pair, waits
  // while the multiply runs, while its result lands and for one cycle
  // after. Without the landing cycle a following write to the pair, or
  // a second multiply, would race the result.
  assign access = psel && penable;
  assign stall = (mi.busy || mi.done || product_fresh) &&
                 ((pwrite && (paddr == OFS_INSTR)) ||
                  (!pwrite && ((paddr == OFS_VIEW_LO) ||
                               (paddr == OFS_VIEW_HI))));
  assign pready = !stall;
  assign pslverr = access && !is_mapped(paddr);
  assign wr_ok = access && pready && pwrite && is_mapped(paddr);
  assign exec = wr_ok && (paddr == OFS_INSTR);

  // Product reads need no gap before a following product write: the
  // write only waits for a multiply, its result landing and one cycle after, never for a read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      product_fresh <= 1'b0;
    end else begin
      product_fresh <= mi.done;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign op = decode_op(strb_merge(WORD_RESET, pwdata, pstrb));
  assign idx = pwdata[15:11];
  assign sel = pwdata[2:0];
  assign high_refused = !ctrl[CTRL_RELEASE2_BIT] &&
                        ((op == OP_FLOAT_HI) || (op == OP_CP2_HI));
  assign rsvd_set = exec && ((op == OP_NONE) || high_refused);
  assign rsvd_clr = wr_ok && (paddr == OFS_STATUS) &&
                    pwdata[STAT_RSVD_BIT];

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ok && (paddr == OFS_CTRL)) begin
      ctrl <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_a <= DWORD_RESET;
      src_b <= DWORD_RESET;
      view_sel <= 10'h000;
    end else if (wr_ok) begin
      case (paddr)
        OFS_SRC_A_LO: src_a[31:0] <= strb_merge(src_a[31:0], pwdata, pstrb);
        OFS_SRC_A_HI: begin
          src_a[63:32] <= strb_merge(src_a[63:32], pwdata, pstrb);
        end
        OFS_SRC_B_LO: src_b[31:0] <= strb_merge(src_b[31:0], pwdata, pstrb);
        OFS_SRC_B_HI: begin
          src_b[63:32] <= strb_merge(src_b[63:32], pwdata, pstrb);
        end
        OFS_VIEW_SEL: view_sel <= pwdata[9:0];
        default: view_sel <= view_sel;
      endcase
    end
  end

  // A refused or unknown instruction leaves a sticky flag; a new refusal
  // in the cycle of a clear keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reserved_instr <= 1'b0;
    end else if (rsvd_set) begin
      reserved_instr <= 1'b1;
    end else if (rsvd_clr) begin
      reserved_instr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // System-control file
  // ----------------------------------------------------------------
  // Only select 0 exists here; other selects are dropped because no
  // register answers to them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        sysctl_file[i] <= DWORD_RESET;
      end
    end else if (exec && (op == OP_SYSCTL) && (sel == 3'h0)) begin
      if (SYSCTL_WIDE_MASK[idx]) begin
        sysctl_file[idx] <= src_a;
      end else begin
        sysctl_file[idx] <= {32'h0000_0000, src_a[31:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Float and coprocessor-2 files
  // ----------------------------------------------------------------
  // The low-half moves clear the upper word: any value is allowed there,
  // and zero keeps the read-back repeatable. The mode bit and odd index
  // case is left to software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        float_register[i] <= DWORD_RESET;
      end
    end else if (exec && (op == OP_FLOAT_LO)) begin
      float_register[idx] <= {32'h0000_0000, src_a[31:0]};
    end else if (exec && (op == OP_FLOAT_HI) && !high_refused) begin
      float_register[idx][63:32] <= src_a[31:0];
    end
  end

  // The selector is simply the register number in bits 15..11; another
  // coprocessor-2 may read that field its own way.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        coproc_register[i] <= DWORD_RESET;
      end
    end else if (exec && (op == OP_CP2_LO)) begin
      coproc_register[idx] <= {32'h0000_0000, src_a[31:0]};
    end else if (exec && (op == OP_CP2_HI) && !high_refused) begin
      coproc_register[idx][63:32] <= src_a[31:0];
    end
  end

  // ----------------------------------------------------------------
  // Product pair
  // ----------------------------------------------------------------
  assign mi.start = exec && (op == OP_UNSIGNED_MULTIPLY_SUBTRACT);
  assign mi.op_b = src_b[31:0];
  assign mi.op_a = src_a[31:0];
  assign mi.acc = {upper_product_register[31:0],
                   bottom_product_register[31:0]};

  // Writing one half after a multiply without reading it first is left
  // to software; the other half simply keeps its value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_product_register <= DWORD_RESET;
      bottom_product_register <= DWORD_RESET;
    end else if (mi.done) begin
      upper_product_register <= sext32(mi.result[63:32]);
      bottom_product_register <= sext32(mi.result[31:0]);
    end else if (exec && (op == OP_UPPER)) begin
      upper_product_register <= src_b;
    end else if (exec && (op == OP_BOTTOM)) begin
      bottom_product_register <= src_b;
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always_comb begin
    case (view_sel[VIEW_SPACE_LSB +: 2])
      SPACE_SYSCTL: view_data = sysctl_file[view_sel[4:0]];
      SPACE_FLOAT: view_data = float_register[view_sel[4:0]];
      SPACE_COPROC2: view_data = coproc_register[view_sel[4:0]];
      SPACE_PRODUCT: begin
        if (view_sel[VIEW_IDX_LSB]) begin
          view_data = bottom_product_register;
        end else begin
          view_data = upper_product_register;
        end
      end
      default: view_data = DWORD_RESET;
    endcase
  end

  always_comb begin
    case (paddr)
      OFS_CTRL: next_prdata = {30'h0000_0000, ctrl};
      OFS_STATUS: begin
        next_prdata = {30'h0000_0000, reserved_instr, mi.busy};
      end
      OFS_SRC_A_LO: next_prdata = src_a[31:0];
      OFS_SRC_A_HI: next_prdata = src_a[63:32];
      OFS_SRC_B_LO: next_prdata = src_b[31:0];
      OFS_SRC_B_HI: next_prdata = src_b[63:32];
      OFS_VIEW_SEL: next_prdata = {22'h00_0000, view_sel};
      OFS_VIEW_LO: next_prdata = view_data[31:0];
      OFS_VIEW_HI: next_prdata = view_data[63:32];
      default: next_prdata = WORD_RESET;
    endcase
  end

  // Read data is caught every selected read cycle, so the access phase shows
  // the state as of the previous edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= WORD_RESET;
    end else if (psel && !pwrite) begin
      prdata <= next_prdata;
    end
  end

endmodule : mtc_unit

// ===== mtc_apb_master.sv
`timescale 1ns/10ps
module mtc_apb_master
  import mtc_pkg::*;
(
  input wire logic pclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // ----------------------------------------------------------------
  // Pipeline-side master issuing one register transfer at a time
  // ----------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // The request is held until pready is seen high; a stall can last
  // for a whole multiply, so no cycle count is assumed here.
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    pstrb <= 4'h0;
  endtask : xfer
endmodule : mtc_apb_master

// ===== mtc_unit_sva.sv
`timescale 1ns/10ps
module mtc_unit_sva
  import mtc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reserved_instr
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire acc = psel && penable;
  wire mapped = (paddr <= OFS_VIEW_HI) && (paddr[1:0] == 2'h0);
  wire instr_wr = acc && pready && pwrite && (paddr == OFS_INSTR);
  wire sts_wr = acc && pready && pwrite && (paddr == OFS_STATUS);

  property p_stall_bounded;
    acc && !pready |-> ##[1:40] pready;
  endproperty
  a_stall_bounded: assert property (p_stall_bounded)
    else $error("stall not released in time");
  property p_write_no_stall;
    acc && pwrite && (paddr != OFS_INSTR) |-> pready;
  endproperty
  a_write_no_stall: assert property (p_write_no_stall)
    else $error("write stalled");
  property p_read_no_stall;
    acc && !pwrite && (paddr != OFS_VIEW_LO) && (paddr != OFS_VIEW_HI)
      |-> pready;
  endproperty
  a_read_no_stall: assert property (p_read_no_stall)
    else $error("read stalled");
  property p_err_map;
    acc |-> (pslverr == !mapped);
  endproperty
  a_err_map: assert property (p_err_map)
    else $error("error response wrong");
  property p_rsvd_cause;
    $rose(reserved_instr) |-> $past(instr_wr);
  endproperty
  a_rsvd_cause: assert property (p_rsvd_cause)
    else $error("reserved flag set without instruction");
  property p_rsvd_hold;
    reserved_instr && !sts_wr |=> reserved_instr;
  endproperty
  a_rsvd_hold: assert property (p_rsvd_hold)
    else $error("reserved flag lost");
  property p_rsvd_clear;
    sts_wr && pwdata[STAT_RSVD_BIT] && !instr_wr |=> !reserved_instr;
  endproperty
  a_rsvd_clear: assert property (p_rsvd_clear)
    else $error("reserved flag not cleared");
  property p_status_view;
    psel && !penable && !pwrite && (paddr == OFS_STATUS)
      |=> prdata[STAT_RSVD_BIT] == $past(reserved_instr);
  endproperty
  a_status_view: assert property (p_status_view)
    else $error("status read does not show flag");

  c_stall: cover property (acc && !pready ##1 pready);
  c_rsvd: cover property ($rose(reserved_instr));
  c_err: cover property (acc && pslverr);
endmodule : mtc_unit_sva

bind mtc_unit mtc_unit_sva u_mtc_unit_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .reserved_instr(reserved_instr)
);

// ===== move_to_coproc_hilo_unit_test.sv
`timescale 1ns/10ps
module move_to_coproc_hilo_unit_test;
  import mtc_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic reserved_instr;
  logic [32:0] exp_q[$];
  logic [32:0] want;
  logic [31:0] rng = 32'h0000_ba08;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;

  mtc_unit u_mtc_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reserved_instr(reserved_instr));
  mtc_apb_master u_mtc_apb_master (.pclk(pclk), .pready(pready),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  function automatic logic [31:0] ins(input logic [5:0] mj,
      input logic [4:0] sub, input logic [4:0] idx, input logic [5:0] fn);
    return {mj, sub, 5'h01, idx, 5'h00, fn};
  endfunction : ins

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    u_mtc_apb_master.xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    u_mtc_apb_master.xfer(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic chk_reg(input logic [1:0] sp, input logic [4:0] idx,
                         input logic [63:0] e);
    wr(OFS_VIEW_SEL, {22'h0, sp, 3'h0, idx});
    rd(OFS_VIEW_LO, {1'b0, e[31:0]});
    rd(OFS_VIEW_HI, {1'b0, e[63:32]});
  endtask : chk_reg

  task automatic ld_src(input logic [63:0] a, input logic [63:0] b);
    wr(OFS_SRC_A_LO, a[31:0]);
    wr(OFS_SRC_A_HI, a[63:32]);
    wr(OFS_SRC_B_LO, b[31:0]);
    wr(OFS_SRC_B_HI, b[63:32]);
  endtask : ld_src

  task automatic end_test(input string s);
    $display("Test %s finished", s);
  endtask : end_test

  task automatic stop_test();
    $display("Checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Clock, watchdog and read monitor
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test();
    end
  end

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      checked++;
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[ERR] %0t unexpected read", $time);
      end else begin
        want = exp_q.pop_front();
        if ({pslverr, prdata} !== want) begin
          n_mismatch++;
          $display("[ERR] %0t read %h want %h", $time, {pslverr, prdata},
                   want);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] t;
    logic [63:0] p;
    logic [63:0] up_v;
    logic [63:0] bot_v;
    logic [63:0] fv[2];
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, {31'h0, CTRL_RESET});
    rd(OFS_STATUS, 33'h0_0000_0000);
    rd(8'h40, {1'b1, 32'h0000_0000});
    end_test("reset");
    a = {xs(), xs()};
    b = {xs(), xs()};
    ld_src(a, b);
    foreach (fv[i]) begin
      t = i ? {32'h0, a[31:0]} : a;
      wr(OFS_INSTR, ins(OPC_SYSCTL, SUB_MOVE_LOW, i ? 5'd3 : 5'd8, 6'h00));
      chk_reg(SPACE_SYSCTL, i ? 5'd3 : 5'd8, t);
    end
    end_test("system control");
    for (int k = 0; k < 2; k++) begin
      a = {xs(), xs()};
      ld_src(a, b);
      wr(OFS_INSTR, ins(k ? OPC_COPROC2 : OPC_FLOAT, SUB_MOVE_LOW, 5'd6,
                        6'h00));
      t = a;
      a = {xs(), xs()};
      ld_src(a, b);
      wr(OFS_INSTR, ins(k ? OPC_COPROC2 : OPC_FLOAT, SUB_MOVE_HIGH, 5'd6,
                        6'h00));
      fv[k] = {a[31:0], t[31:0]};
      chk_reg(k ? SPACE_COPROC2 : SPACE_FLOAT, 5'd6, fv[k]);
      wr(OFS_INSTR, ins(k ? OPC_COPROC2 : OPC_FLOAT, SUB_MOVE_LOW, 5'd7,
                        6'h00));
      t = {32'h0, a[31:0]};
      chk_reg(k ? SPACE_COPROC2 : SPACE_FLOAT, 5'd7, t);
    end
    end_test("float and coprocessor");
    up_v = {xs(), xs()};
    bot_v = {xs(), xs()};
    ld_src(a, up_v);
    wr(OFS_INSTR, ins(OPC_SPECIAL, 5'd2, 5'd0, FN_WRITE_UPPER));
    ld_src(a, bot_v);
    wr(OFS_INSTR, ins(OPC_SPECIAL, 5'd2, 5'd0, FN_WRITE_BOTTOM));
    chk_reg(SPACE_PRODUCT, 5'd0, up_v);
    chk_reg(SPACE_PRODUCT, 5'd1, bot_v);
    rd(OFS_STATUS, 33'h0_0000_0000);
    end_test("product writes");
    a = {xs(), xs() >> 20};
    b = {xs(), xs()};
    ld_src(a, b);
    wr(OFS_INSTR, ins(OPC_SPECIAL2, 5'd2, 5'd1, FN_MSUB_UNSIGNED));
    wr(OFS_INSTR, ins(OPC_SPECIAL2, 5'd2, 5'd1, FN_MSUB_UNSIGNED));
    p = {32'h0, a[31:0]} * {32'h0, b[31:0]};
    t = {up_v[31:0], bot_v[31:0]} - p - p;
    chk_reg(SPACE_PRODUCT, 5'd0, {{32{t[63]}}, t[63:32]});
    chk_reg(SPACE_PRODUCT, 5'd1, {{32{t[31]}}, t[31:0]});
    end_test("multiply subtract");
    wr(OFS_CTRL, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_INSTR, ins(k ? OPC_COPROC2 : OPC_FLOAT, SUB_MOVE_HIGH, 5'd6,
                        6'h00));
      rd(OFS_STATUS, {1'b0, 32'h0000_0002});
      chk_reg(k ? SPACE_COPROC2 : SPACE_FLOAT, 5'd6, fv[k]);
      wr(OFS_STATUS, 32'h0000_0002);
      rd(OFS_STATUS, 33'h0_0000_0000);
    end
    wr(OFS_CTRL, 32'h0000_0002);
    end_test("older release");
    repeat (2) @(posedge pclk);
    stop_test();
  end
endmodule : move_to_coproc_hilo_unit_test
